// File: core/sep_pkg.sv
// sep_pkg: constants and types shared by both ends of the serial eeprom link
// assumes: both ends run on one 100 MHz clk; the bench joins them through sep_bus_if
package sep_pkg;
   // =====================================================================
   // timing
   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          LINK_PERIOD_NS     = 160;
   localparam int          QTR_CYCLES         = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
   localparam int          WRITE_CYCLE_CYCLES = 2000;
   // =====================================================================
   // control byte, array and byte framing
   localparam logic [3:0]  CTRL_CODE          = 4'ha;
   localparam logic        RW_READ            = 1'b1;
   localparam int          MEM_DEPTH          = 8192;
   localparam int          PAGE_SIZE          = 32;
   localparam logic [3:0]  ACK_SLOT           = 4'h8;
   localparam logic [3:0]  BYTE_END           = 4'h9;
   // =====================================================================
   // values after reset
   localparam logic [5:0]  PIN_RST            = 6'h03;
   localparam logic [12:0] PTR_RST            = 13'h0000;
   // =====================================================================
   // types
   typedef enum logic [1:0] {OP_WRITE, OP_CUR_READ, OP_RAND_READ} sep_op_t;
   typedef enum logic [2:0] {DS_IDLE, DS_CTRL, DS_AH, DS_AL, DS_WDATA, DS_READ} sep_dstate_t;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} sep_hstate_t;
   typedef enum logic [2:0] {ST_CTRL_W, ST_AH, ST_AL, ST_DATA, ST_CTRL_R, ST_READ, ST_POLL,
                             ST_DONE} sep_step_t;
endpackage : sep_pkg

// File: core/sep_bus_if.sv
// sep_bus_if: the two-wire link between master and eeprom
// assumes: sda is open-drain with a pull-up, resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface sep_bus_if;
   logic scl;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic sda;
   // =====================================================================
   // wired-and with pull-up
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport master (output scl, sda_m_o, sda_m_oe, input sda);
   modport slave  (input scl, sda, output sda_s_o, sda_s_oe);
endinterface : sep_bus_if
`default_nettype wire

// File: core/sep_buf2.sv
// sep_buf2: two-entry buffer with valid and ready on both sides
// assumes: one clock; outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none
module sep_buf2
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       in_valid,
   output var  logic       in_ready,
   input  wire logic [7:0] in_data,
   output var  logic       out_valid,
   input  wire logic       out_ready,
   output var  logic [7:0] out_data
);
   logic       ov_q, ov_d, sv_q, sv_d;
   logic [7:0] od_q, od_d, sd_q, sd_d;
   logic       push;
   // =====================================================================
   // next state
   always_comb
   begin
      push = in_valid && !sv_q;
      ov_d = ov_q;
      od_d = od_q;
      sv_d = sv_q;
      sd_d = sd_q;
      if (!ov_q || out_ready)
      begin
         if (sv_q)
         begin
            od_d = sd_q;
            ov_d = 1'b1;
            sv_d = push;
            sd_d = in_data;
         end
         else
         begin
            ov_d = push;
            od_d = in_data;
         end
      end
      else if (push)
      begin
         sv_d = 1'b1;
         sd_d = in_data;
      end
   end
   // =====================================================================
   // registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ov_q <= 1'b0;
         sv_q <= 1'b0;
         od_q <= 8'h00;
         sd_q <= 8'h00;
      end
      else if (ce)
      begin
         ov_q <= ov_d;
         sv_q <= sv_d;
         od_q <= od_d;
         sd_q <= sd_d;
      end
   end
   assign in_ready  = !sv_q;
   assign out_valid = ov_q;
   assign out_data  = od_q;
endmodule : sep_buf2
`default_nettype wire

// File: core/sep_device.sv
// sep_device: two-wire serial eeprom slave, 8192 x 8 array with page buffer
// assumes: scl, sda, wp and chip selects are asynchronous pins; sda is open-drain
//
// Contract
// - no acknowledge at all during write cycle
// - master may poll right after write stop
// - unanswered poll: master resends start and control
// - after write cycle, matching control byte acknowledged
// - read differs from write only in direction bit
// - address counter holds last address plus one
// - current read: ack, send byte at counter
// - random read: address loaded though write abandoned
// - after restart and read control, send addressed byte
// - after random read counter points past it
// - master ack fetches next consecutive byte
// - master ends read with no ack, stop
// - pointer increments after each byte transfer
// - pointer wraps from top to bottom
// - respond only when three chip selects match
// - data changes only while clock low
// - data line open-drain: pull low or release
// - write protect high inhibits array writes
// - write protect low leaves array writable
// - control byte: type code, selects, direction
// - two address bytes, high first, thirteen bits
// - write protect sampled at write stop
`timescale 1ns/1ps
`default_nettype none
module sep_device
#(
   parameter int unsigned TWC_CYCLES = sep_pkg::WRITE_CYCLE_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   sep_bus_if.slave  bus,
   input  wire logic wp,
   input  wire logic chip_select_in_0,
   input  wire logic chip_select_in_1,
   input  wire logic chip_select_in_2,
   output var  logic busy
);
   import sep_pkg::*;

   localparam logic [15:0] TWC_LAST = 16'(TWC_CYCLES - 1);

   logic [7:0]  mem [0:MEM_DEPTH-1];
   logic [7:0]  pbuf [0:PAGE_SIZE-1];
   logic [5:0]  pin_raw, pin_s1_q, pin_s2_q;
   logic [1:0]  prev_q;
   logic        scl_s, sda_s, wp_s;
   logic [2:0]  cs_s;
   logic        scl_rise, scl_fall, start_ev, stop_ev;
   sep_dstate_t st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d, rd_byte;
   logic [4:0]  ah_q, ah_d;
   logic [12:0] ptr_q, ptr_d;
   logic [7:0]  pbase_q, pbase_d;
   logic [31:0] pval_q, pval_d;
   logic        oe_q, oe_d, mack_q, mack_d, pend_q, pend_d;
   logic        ctrl_ok, load, pwe;
   logic        busy_q, busy_d, mem_we;
   logic [15:0] tmr_q, tmr_d;

   // =====================================================================
   // pin synchronisers and line events
   assign pin_raw = {chip_select_in_2, chip_select_in_1, chip_select_in_0, wp, bus.sda, bus.scl};
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_s1_q <= PIN_RST;
         pin_s2_q <= PIN_RST;
         prev_q   <= 2'h3;
      end
      else if (ce)
      begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         prev_q   <= pin_s2_q[1:0];
      end
   end
   assign scl_s    = pin_s2_q[0];
   assign sda_s    = pin_s2_q[1];
   // floating default comes from the board pull-down; only the level matters here
   assign wp_s     = pin_s2_q[2];
   assign cs_s     = pin_s2_q[5:3];
   assign scl_rise = scl_s && !prev_q[0];
   assign scl_fall = !scl_s && prev_q[0];
   // sda moving while scl high is only ever start or stop
   assign start_ev = scl_s && prev_q[0] && prev_q[1] && !sda_s;
   assign stop_ev  = scl_s && prev_q[0] && !prev_q[1] && sda_s;

   // =====================================================================
   // protocol engine
   always_comb
   begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ah_d    = ah_q;
      ptr_d   = ptr_q;
      oe_d    = oe_q;
      mack_d  = mack_q;
      pend_d  = pend_q;
      pval_d  = pval_q;
      pbase_d = pbase_q;
      pwe     = 1'b0;
      load    = 1'b0;
      rd_byte = mem[ptr_q];
      ctrl_ok = (sh_q[7:4] == CTRL_CODE) && (sh_q[3:1] == cs_s)
                && !busy_q;
      if (start_ev)
      begin
         st_d   = DS_CTRL;
         cnt_d  = 4'h0;
         oe_d   = 1'b0;
         pend_d = 1'b0;
      end
      else if (stop_ev)
      begin
         st_d   = DS_IDLE;
         oe_d   = 1'b0;
         pend_d = 1'b0;
      end
      else if (st_q != DS_IDLE && scl_rise)
      begin
         // sample only on the rising clock
         if (cnt_q == ACK_SLOT)
            mack_d = !sda_s;
         else if (st_q != DS_READ)
            sh_d = {sh_q[6:0], sda_s};
         cnt_d = cnt_q + 4'h1;
      end
      else if (st_q != DS_IDLE && scl_fall)
      begin
         if (cnt_q == ACK_SLOT)
         begin
            // acknowledge received bytes; let go while master answers
            oe_d = (st_q != DS_READ) && (st_q != DS_CTRL || ctrl_ok);
         end
         else if (cnt_q == BYTE_END)
         begin
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            case (st_q)
               DS_CTRL:
               begin
                  if (!oe_q)
                     st_d = DS_IDLE;
                  else if (sh_q[0] == RW_READ)
                  begin
                     st_d = DS_READ;
                     load = 1'b1;
                  end
                  else
                     st_d = DS_AH;
               end
               DS_AH:
               begin
                  ah_d = sh_q[4:0];
                  st_d = DS_AL;
               end
               DS_AL:
               begin
                  ptr_d  = {ah_q, sh_q};
                  pval_d = 32'h0000_0000;
                  st_d   = DS_WDATA;
               end
               DS_WDATA:
               begin
                  pwe                  = 1'b1;
                  pbase_d              = ptr_q[12:5];
                  pval_d[ptr_q[4:0]]   = 1'b1;
                  ptr_d                = {ptr_q[12:5], 5'(ptr_q[4:0] + 5'h01)};
                  pend_d               = 1'b1;
               end
               DS_READ:
               begin
                  if (mack_q)
                     load = 1'b1;
                  else
                     st_d = DS_IDLE;
               end
               default:
                  st_d = DS_IDLE;
            endcase
         end
         else if (st_q == DS_READ)
         begin
            oe_d = !sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
         end
      end
      if (load)
      begin
         oe_d  = !rd_byte[7];
         sh_d  = {rd_byte[6:0], 1'b0};
         ptr_d = ptr_q + 13'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q    <= DS_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         ah_q    <= 5'h00;
         ptr_q   <= PTR_RST;
         oe_q    <= 1'b0;
         mack_q  <= 1'b0;
         pend_q  <= 1'b0;
         pval_q  <= 32'h0000_0000;
         pbase_q <= 8'h00;
      end
      else if (ce)
      begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ah_q    <= ah_d;
         ptr_q   <= ptr_d;
         oe_q    <= oe_d;
         mack_q  <= mack_d;
         pend_q  <= pend_d;
         pval_q  <= pval_d;
         pbase_q <= pbase_d;
      end
   end

   // =====================================================================
   // self-timed write cycle: copies the page buffer into the array
   always_comb
   begin
      busy_d = busy_q;
      tmr_d  = tmr_q;
      mem_we = 1'b0;
      if (busy_q)
      begin
         mem_we = (tmr_q[15:5] == 11'h000) && pval_q[tmr_q[4:0]];
         if (tmr_q == TWC_LAST)
            busy_d = 1'b0;
         else
            tmr_d = tmr_q + 16'h0001;
      end
      else if (stop_ev && pend_q && !wp_s)
      begin
         busy_d = 1'b1;
         tmr_d  = 16'h0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         tmr_q  <= 16'h0000;
      end
      else if (ce)
      begin
         busy_q <= busy_d;
         tmr_q  <= tmr_d;
      end
   end

   // =====================================================================
   // array and page buffer storage
   always_ff @(posedge clk)
   begin
      if (ce && mem_we)
         mem[{pbase_q, tmr_q[4:0]}] <= pbuf[tmr_q[4:0]];
      if (ce && pwe)
         pbuf[ptr_q[4:0]] <= sh_q;
   end

   assign bus.sda_s_o  = 1'b0;
   assign bus.sda_s_oe = oe_q;
   assign busy         = busy_q;
endmodule : sep_device
`default_nettype wire

// File: core/sep_host.sv
// sep_host: two-wire master issuing byte writes with ack polling and reads
// assumes: clk at 100 MHz; scl made here by a divider; read data leaves through sep_buf2
`timescale 1ns/1ps
`default_nettype none
module sep_host
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   sep_bus_if.master             bus,
   input  wire logic             cmd_valid,
   output var  logic             cmd_ready,
   input  wire sep_pkg::sep_op_t cmd_op,
   input  wire logic [2:0]       cmd_cs,
   input  wire logic [15:0]      cmd_addr,
   input  wire logic [7:0]       cmd_wdata,
   input  wire logic [7:0]       cmd_count,
   output var  logic             rd_valid,
   input  wire logic             rd_ready,
   output var  logic [7:0]       rd_data,
   output var  logic             nak_err
);
   import sep_pkg::*;

   localparam logic [3:0] DV_LAST = 4'(QTR_CYCLES - 1);

   sep_hstate_t hs_q, hs_d;
   sep_step_t   st_q, st_d;
   sep_op_t     op_q, op_d;
   logic [1:0]  qt_q, qt_d;
   logic [3:0]  dv_q, dv_d, cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d, left_q, left_d, wd_q, wd_d;
   logic [15:0] ad_q, ad_d;
   logic [2:0]  cs_q, cs_d;
   logic        scl_q, scl_d, oe_q, oe_d, rdy_q, rdy_d, err_q, err_d, push_q, push_d;
   logic        sda_s1_q, sda_s2_q, tick, lvl, buf_rdy;

   // =====================================================================
   // sequencer
   always_comb
   begin
      hs_d   = hs_q;
      st_d   = st_q;
      op_d   = op_q;
      qt_d   = qt_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      left_d = left_q;
      wd_d   = wd_q;
      ad_d   = ad_q;
      cs_d   = cs_q;
      rdy_d  = rdy_q;
      err_d  = 1'b0;
      push_d = 1'b0;
      tick   = (dv_q == DV_LAST);
      dv_d   = (hs_q == HS_IDLE || tick) ? 4'h0 : dv_q + 4'h1;
      if (hs_q == HS_IDLE)
      begin
         if (cmd_valid && rdy_q)
         begin
            op_d   = cmd_op;
            cs_d   = cmd_cs;
            ad_d   = cmd_addr;
            wd_d   = cmd_wdata;
            left_d = cmd_count;
            rdy_d  = 1'b0;
            qt_d   = 2'h0;
            hs_d   = HS_START;
            st_d   = (cmd_op == OP_CUR_READ) ? ST_CTRL_R : ST_CTRL_W;
         end
      end
      else if (tick)
      begin
         if (qt_q != 2'h3)
         begin
            // hold scl low before a read byte until the buffer has room
            if (!(hs_q == HS_BIT && st_q == ST_READ && cnt_q == 4'h0 && qt_q == 2'h0
                  && !buf_rdy))
               qt_d = qt_q + 2'h1;
         end
         else
         begin
            qt_d = 2'h0;
            case (hs_q)
               HS_START:
               begin
                  hs_d  = HS_BIT;
                  cnt_d = 4'h0;
                  sh_d  = {CTRL_CODE, cs_q, st_q == ST_CTRL_R};
               end
               HS_STOP:
               begin
                  if (st_q == ST_DATA)
                  begin
                     hs_d = HS_START;
                     st_d = ST_POLL;
                  end
                  else
                  begin
                     hs_d  = HS_IDLE;
                     rdy_d = 1'b1;
                  end
               end
               HS_BIT:
               begin
                  if (cnt_q != ACK_SLOT)
                  begin
                     sh_d  = {sh_q[6:0], sda_s2_q};
                     cnt_d = cnt_q + 4'h1;
                  end
                  else
                  begin
                     cnt_d = 4'h0;
                     case (st_q)
                        ST_CTRL_W, ST_CTRL_R:
                        begin
                           if (sda_s2_q)
                           begin
                              hs_d  = HS_STOP;
                              st_d  = ST_DONE;
                              err_d = 1'b1;
                           end
                           else if (st_q == ST_CTRL_R)
                              st_d = ST_READ;
                           else
                           begin
                              st_d = ST_AH;
                              sh_d = ad_q[15:8];
                           end
                        end
                        ST_POLL:
                        begin
                           if (sda_s2_q)
                              hs_d = HS_START;
                           else
                           begin
                              hs_d = HS_STOP;
                              st_d = ST_DONE;
                           end
                        end
                        ST_AH:
                        begin
                           st_d = ST_AL;
                           sh_d = ad_q[7:0];
                        end
                        ST_AL:
                        begin
                           if (op_q == OP_WRITE)
                           begin
                              st_d = ST_DATA;
                              sh_d = wd_q;
                           end
                           else
                           begin
                              hs_d = HS_START;
                              st_d = ST_CTRL_R;
                           end
                        end
                        ST_DATA:
                           hs_d = HS_STOP;
                        ST_READ:
                        begin
                           push_d = 1'b1;
                           left_d = left_q - 8'h01;
                           if (left_q == 8'h01)
                           begin
                              hs_d = HS_STOP;
                              st_d = ST_DONE;
                           end
                        end
                        default:
                           hs_d = HS_STOP;
                     endcase
                  end
               end
               default:
                  hs_d = HS_IDLE;
            endcase
         end
      end
      // line levels for the coming quarter
      case (hs_d)
         HS_START:
         begin
            scl_d = (qt_d != 2'h0);
            lvl   = !qt_d[1];
         end
         HS_STOP:
         begin
            scl_d = (qt_d != 2'h0);
            lvl   = qt_d[1];
         end
         HS_BIT:
         begin
            scl_d = qt_d[1];
            if (cnt_d == ACK_SLOT)
               lvl = (st_d != ST_READ) || (left_d == 8'h01);
            else
               lvl = (st_d == ST_READ) || sh_d[7];
         end
         default:
         begin
            scl_d = 1'b1;
            lvl   = 1'b1;
         end
      endcase
      oe_d = !lvl;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hs_q <= HS_IDLE;
         st_q <= ST_DONE;
         op_q <= OP_WRITE;
         qt_q <= 2'h0;
         dv_q <= 4'h0;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         left_q <= 8'h00;
         wd_q <= 8'h00;
         ad_q <= 16'h0000;
         cs_q <= 3'h0;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         rdy_q <= 1'b1;
         err_q <= 1'b0;
         push_q <= 1'b0;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end
      else if (ce)
      begin
         hs_q <= hs_d;
         st_q <= st_d;
         op_q <= op_d;
         qt_q <= qt_d;
         dv_q <= dv_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         left_q <= left_d;
         wd_q <= wd_d;
         ad_q <= ad_d;
         cs_q <= cs_d;
         scl_q <= scl_d;
         oe_q <= oe_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         push_q <= push_d;
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   // =====================================================================
   // read data buffer
   sep_buf2 u_buf
   (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .in_valid  (push_q),
      .in_ready  (buf_rdy),
      .in_data   (sh_q),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   assign bus.scl      = scl_q;
   assign bus.sda_m_o  = 1'b0;
   assign bus.sda_m_oe = oe_q;
   assign cmd_ready    = rdy_q;
   assign nak_err      = err_q;
endmodule : sep_host
`default_nettype wire

// File: tb/sep_link_sva.sv
// sep_link_sva: checks on the two-wire link
// assumes: placed beside sep_bus_if, fed its signals
`timescale 1ns/1ps
`default_nettype none
module sep_link_sva
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==================================================================
   // device side of the wire
   a_busy_no_ack: assert property (busy |-> !sda_s_oe)
      else $error("ack while busy");
   a_busy_holds: assert property ($rose(busy) |-> busy[*8])
      else $error("write cycle too short");
   a_busy_at_stop: assert property ($rose(busy) |-> scl && sda)
      else $error("write cycle not after stop");
   a_oe_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
      else $error("data moved in high phase");
   a_oe_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("data unstable in high phase");
   a_pull_low: assert property (sda_s_oe |-> !sda)
      else $error("driven line not low");
   a_start_host: assert property (scl && $past(scl) && $fell(sda) |-> !sda_s_oe)
      else $error("device made a start");
   a_stop_free: assert property (scl && $past(scl) && $rose(sda) |=> !sda_s_oe[*4])
      else $error("device drives after stop");
endmodule : sep_link_sva
`default_nettype wire

// File: tb/serial_eeprom_read_and_poll_test.sv
// serial_eeprom_read_and_poll_test: host and device back to back
// assumes: core files and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_and_poll_test;
   import sep_pkg::*;
   typedef struct packed {sep_op_t op; logic [15:0] a; logic [15:0] d; logic [7:0] n;} sep_row_t;
   logic        clk = 0, rst = 1, cmd_valid = 0, rd_ready = 1, wp = 0, ce = 1;
   logic        cmd_ready, rd_valid, nak_err, busy;
   sep_op_t     cmd_op = OP_WRITE;
   logic [2:0]  cmd_cs = 3'h2;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0]  cmd_wdata = 8'h00, cmd_count = 8'h01, rd_data;
   logic [7:0]  got [$];
   int          failures = 0, tests_run = 0, naks = 0;
   sep_row_t    rows [5] = '{'{OP_WRITE, 16'h1fff, 16'h00a5, 8'h00},
      '{OP_WRITE, 16'he000, 16'h003c, 8'h00}, '{OP_WRITE, 16'h0001, 16'h0069, 8'h00},
      '{OP_RAND_READ, 16'h1fff, 16'ha53c, 8'h02}, '{OP_CUR_READ, 16'h0000, 16'h6900, 8'h01}};
   sep_bus_if bus ();
   sep_host u_sep_host (.clk, .rst, .ce, .bus(bus.master), .cmd_valid, .cmd_ready,
      .cmd_op, .cmd_cs, .cmd_addr, .cmd_wdata, .cmd_count, .rd_valid, .rd_ready, .rd_data,
      .nak_err);
   // write cycle outlasts one poll, so polls go unanswered before the ack
   sep_device #(.TWC_CYCLES(400)) u_sep_device (.clk, .rst, .ce, .bus(bus.slave), .wp,
      .chip_select_in_0(1'b0), .chip_select_in_1(1'b1), .chip_select_in_2(1'b0), .busy);
   sep_link_sva u_sep_link_sva (.clk, .rst, .scl(bus.scl), .sda(bus.sda),
      .sda_s_oe(bus.sda_s_oe), .busy);
   // ==================================================================
   // clock, watchdog, read collector
   initial forever #5 clk = ~clk;
   initial
   begin
      #400000;
      failures++;
      close_out();
   end
   always @(posedge clk)
   begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
      if (nak_err === 1'b1) naks++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want) failures++;
      if (seen !== want) $display("BAD %0t seen %h want %h", $time, seen, want);
   endtask : check
   task automatic run(input sep_op_t op, input logic [15:0] a, input logic [7:0] d, n);
      got = {};
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_count <= n;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      do @(negedge clk); while (cmd_ready !== 1'b1);
      @(posedge clk);
   endtask : run
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // ==================================================================
   // table, then reset, chip select, protect and stall cases
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i])
      begin
         run(rows[i].op, rows[i].a, rows[i].d[7:0], rows[i].n);
         for (int j = 0; j < rows[i].n; j++) check(got[j], rows[i].d[15-8*j -: 8]);
         $display("row %0d done", i);
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({7'h00, busy}, 8'h00);
      check({7'h00, bus.sda_s_oe}, 8'h00);
      @(posedge clk);
      run(OP_CUR_READ, 16'h0000, 8'h00, 8'h01);
      check(got[0], 8'h3c);
      $display("reset done");
      cmd_cs <= 3'h5;
      run(OP_CUR_READ, 16'h0000, 8'h00, 8'h01);
      check(8'(naks), 8'h01);
      check(8'(got.size()), 8'h00);
      cmd_cs <= 3'h2;
      wp <= 1'b1;
      run(OP_WRITE, 16'h0001, 8'h00, 8'h00);
      wp <= 1'b0;
      run(OP_RAND_READ, 16'h0001, 8'h00, 8'h01);
      check(got[0], 8'h69);
      $display("select and protect done");
      rd_ready <= 1'b0;
      fork
         begin
            // freeze both ends mid transfer; no byte may be lost
            repeat (300) @(posedge clk);
            ce <= 1'b0;
            repeat (40) @(posedge clk);
            ce <= 1'b1;
            repeat (1160) @(posedge clk);
            rd_ready <= 1'b1;
         end
      join_none
      run(OP_RAND_READ, 16'h1fff, 8'h00, 8'h03);
      check(got[0], 8'ha5);
      check(got[2], 8'h69);
      check(got[1], 8'h3c);
      $display("stall done");
      close_out();
   end
endmodule : serial_eeprom_read_and_poll_test
`default_nettype wire
